/* design/universal_serial_shift_pkg.sv */
// constants for the universal serial shift core: modes, clock sources,
// widths, reset values, pin-level indices and serial-rate limits.
// assumes the core runs on a 20 MHz system clock.
package universal_serial_shift_pkg;

  // widths of the shift register and the edge/bit counter
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 4;

  // reset values and counter constants
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_MAX  = 4'hF;
  localparam logic [3:0] CNT_STEP = 4'h1;

  // wire modes
  localparam logic [1:0] WIRE_OFF      = 2'h0;
  localparam logic [1:0] WIRE_THREE    = 2'h1;
  localparam logic [1:0] WIRE_TWO      = 2'h2;
  localparam logic [1:0] WIRE_TWO_HOLD = 2'h3; // two-wire, also hold clock after overflow

  // shared shift clock sources
  localparam logic [1:0] SRC_SOFT  = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;

  // bit positions of the filtered pin levels crossing into the core
  localparam int unsigned LVL_SCK   = 0;
  localparam int unsigned LVL_DI    = 1;
  localparam int unsigned LVL_START = 2;
  localparam int unsigned LVL_W     = 3;

  // bit positions of the pin requests crossing out to the link
  localparam int unsigned REQ_DO_LVL = 0;
  localparam int unsigned REQ_DO_EN  = 1;
  localparam int unsigned REQ_SDA_LO = 2;
  localparam int unsigned REQ_SCL_LO = 3;
  localparam int unsigned REQ_W      = 4;

  // serial rate limits as fractions of the system clock
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned TWO_WIRE_DIV   = 16;
  localparam int unsigned THREE_WIRE_DIV = 4;
  localparam logic [4:0]  GAP_MIN_TWO    = 5'(TWO_WIRE_DIV / 2);
  localparam logic [4:0]  GAP_MIN_THREE  = 5'(THREE_WIRE_DIV / 2);
  localparam logic [4:0]  GAP_SAT        = 5'h1F;
  localparam logic [4:0]  GAP_STEP       = 5'h01;

endpackage

/* design/universal_serial_shift_core.sv */
// universal serial shift core: 8-bit shift register and 4-bit counter on one
// selectable clock, pin conditioning on the link clock, two-wire start detector
// and clock stretching.
// assumes link_clk runs free and faster than the serial clock; control and
// status are plain ports of the core, pulses last one sys_clk cycle.

`timescale 1ns/10ps
`default_nettype none

module universal_serial_shift_core (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic [1:0] wire_mode,
  input  wire logic [1:0] clock_source,
  input  wire logic       clock_edge_select,
  input  wire logic       timer_match,
  input  wire logic       soft_strobe,
  input  wire logic       data_wr_en,
  input  wire logic [7:0] data_wr,
  input  wire logic       cnt_wr_en,
  input  wire logic [3:0] cnt_wr,
  input  wire logic       overflow_clr,
  input  wire logic       start_clr,
  input  wire logic       rate_clr,
  input  wire logic       overflow_irq_en,
  input  wire logic       start_irq_en,
  input  wire logic       serial_in_pin,
  output logic            serial_in_pin_out,
  output logic            serial_in_pin_oe,
  input  wire logic       shift_clock_pin,
  output logic            shift_clock_pin_out,
  output logic            shift_clock_pin_oe,
  output logic            data_out_pin,
  output logic            data_out_pin_oe,
  output logic [7:0]      data_q,
  output logic [3:0]      cnt_q,
  output logic            counter_overflow_flag,
  output logic            start_flag,
  output logic            rate_error,
  output logic            irq,
  output logic            wake_idle,
  output logic            wake_deep
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by several processes
  function automatic logic is_two_wire(input logic [1:0] mode);
    is_two_wire = (mode == universal_serial_shift_pkg::WIRE_TWO) ||
                  (mode == universal_serial_shift_pkg::WIRE_TWO_HOLD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link domain: pin conditioning and start detection
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;
  logic [1:0] pin_s3_ff;
  logic [1:0] pin_flt_ff;
  logic       sda_prev_ff;
  logic       start_tgl_ff;

  assign pin_raw = {serial_in_pin, shift_clock_pin};

  // three stages per pin; a level counts only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin_sync
      always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
          pin_s1_ff[gi]  <= 1'b1;
          pin_s2_ff[gi]  <= 1'b1;
          pin_s3_ff[gi]  <= 1'b1;
          pin_flt_ff[gi] <= 1'b1;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
          pin_s3_ff[gi] <= pin_s2_ff[gi];
          if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
            pin_flt_ff[gi] <= pin_s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  // start: data line falls while clock line is high; a toggle carries the event
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      sda_prev_ff  <= 1'b1;
      start_tgl_ff <= 1'b0;
    end else begin
      sda_prev_ff <= pin_flt_ff[1];
      if (sda_prev_ff && !pin_flt_ff[1] && pin_flt_ff[0]) begin
        start_tgl_ff <= ~start_tgl_ff;
      end
    end
  end

  // pin requests from the core cross with two flip-flops; the second feeds the pin registers
  logic [3:0] req_ff;
  logic [3:0] req_a_ff;
  logic [3:0] req_b_ff;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      req_a_ff <= 4'h0;
      req_b_ff <= 4'h0;
    end else begin
      req_a_ff <= req_ff;
      req_b_ff <= req_a_ff;
    end
  end

  // pins are open-drain pull-downs in two-wire mode, so driven value stays low
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      serial_in_pin_out   <= 1'b0;
      serial_in_pin_oe    <= 1'b0;
      shift_clock_pin_out <= 1'b0;
      shift_clock_pin_oe  <= 1'b0;
      data_out_pin        <= 1'b0;
      data_out_pin_oe     <= 1'b0;
    end else begin
      serial_in_pin_out   <= 1'b0;
      serial_in_pin_oe    <= req_b_ff[universal_serial_shift_pkg::REQ_SDA_LO];
      shift_clock_pin_out <= 1'b0;
      shift_clock_pin_oe  <= req_b_ff[universal_serial_shift_pkg::REQ_SCL_LO];
      data_out_pin        <= req_b_ff[universal_serial_shift_pkg::REQ_DO_LVL];
      data_out_pin_oe     <= req_b_ff[universal_serial_shift_pkg::REQ_DO_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain: level crossing of the filtered pins and the start toggle
  logic [2:0] lvl_a_ff;
  logic [2:0] lvl_b_ff;
  logic       sck_prev_ff;
  logic       start_prev_ff;

  // clock and data cross together, so a sampled bit lines up with its edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvl_a_ff      <= 3'h3;
      lvl_b_ff      <= 3'h3;
      sck_prev_ff   <= 1'b1;
      start_prev_ff <= 1'b0;
    end else begin
      lvl_a_ff      <= {start_tgl_ff, pin_flt_ff};
      lvl_b_ff      <= lvl_a_ff;
      sck_prev_ff   <= lvl_b_ff[universal_serial_shift_pkg::LVL_SCK];
      start_prev_ff <= lvl_b_ff[universal_serial_shift_pkg::LVL_START];
    end
  end

  logic sck_lvl;
  logic di_lvl;
  logic ext_edge;
  logic sample_edge;
  logic start_evt;
  logic src_ext;
  logic shift_evt;
  logic cnt_evt;
  logic ovf_evt;

  assign sck_lvl   = lvl_b_ff[universal_serial_shift_pkg::LVL_SCK];
  assign di_lvl    = lvl_b_ff[universal_serial_shift_pkg::LVL_DI];
  assign ext_edge  = sck_lvl ^ sck_prev_ff;
  assign start_evt = (lvl_b_ff[universal_serial_shift_pkg::LVL_START] ^ start_prev_ff) &&
                     is_two_wire(wire_mode);
  assign src_ext   = (clock_source == universal_serial_shift_pkg::SRC_EXT);

  // sampling edge: rising with edge select clear, falling with it set
  assign sample_edge = ext_edge && (sck_lvl ^ clock_edge_select);

  // one selected source clocks both the register and the counter
  always_comb begin
    case (clock_source)
      universal_serial_shift_pkg::SRC_EXT: begin
        shift_evt = sample_edge;
        cnt_evt   = ext_edge;
      end
      universal_serial_shift_pkg::SRC_TIMER: begin
        shift_evt = timer_match;
        cnt_evt   = timer_match;
      end
      universal_serial_shift_pkg::SRC_SOFT: begin
        shift_evt = soft_strobe;
        cnt_evt   = soft_strobe;
      end
      default: begin
        shift_evt = 1'b0;
        cnt_evt   = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift register and counter
  logic [7:0] data_ff;
  logic [3:0] cnt_ff;

  // a write wins over a shift; no copy is kept, so the next shift destroys data
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_ff <= universal_serial_shift_pkg::DATA_RST;
    end else if (data_wr_en) begin
      data_ff <= data_wr;
    end else if (shift_evt) begin
      data_ff <= {data_ff[6:0], di_lvl};
    end
  end

  assign ovf_evt = cnt_evt && !cnt_wr_en && (cnt_ff == universal_serial_shift_pkg::CNT_MAX);

  // sixteen edges from zero make one byte; wraps to zero on overflow
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= universal_serial_shift_pkg::CNT_ZERO;
    end else if (cnt_wr_en) begin
      cnt_ff <= cnt_wr;
    end else if (cnt_evt) begin
      cnt_ff <= cnt_ff + universal_serial_shift_pkg::CNT_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latch: with the external clock, transparent only in the phase after the output-change edge; always transparent otherwise
  logic latch_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      latch_ff <= 1'b0;
    end else if (!src_ext || (sck_lvl == clock_edge_select)) begin
      latch_ff <= data_ff[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags: a set in the clear cycle wins
  logic ovf_flag_ff;
  logic start_flag_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_flag_ff <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_ff <= 1'b1;
    end else if (overflow_clr) begin
      ovf_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_flag_ff <= 1'b0;
    end else if (start_evt) begin
      start_flag_ff <= 1'b1;
    end else if (start_clr) begin
      start_flag_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial rate monitor: half periods shorter than the limit are flagged,
  // since the pin path cannot resolve edges that close together
  logic [4:0] gap_ff;
  logic [4:0] gap_min;
  logic       rate_err_ff;

  assign gap_min = is_two_wire(wire_mode) ? universal_serial_shift_pkg::GAP_MIN_TWO
                                          : universal_serial_shift_pkg::GAP_MIN_THREE;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_ff <= universal_serial_shift_pkg::GAP_SAT;
    end else if (ext_edge) begin
      gap_ff <= universal_serial_shift_pkg::GAP_STEP;
    end else if (gap_ff != universal_serial_shift_pkg::GAP_SAT) begin
      gap_ff <= gap_ff + universal_serial_shift_pkg::GAP_STEP;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rate_err_ff <= 1'b0;
    end else if (ext_edge && src_ext && (wire_mode != universal_serial_shift_pkg::WIRE_OFF) &&
                 (gap_ff < gap_min)) begin
      rate_err_ff <= 1'b1;
    end else if (rate_clr) begin
      rate_err_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin requests: msb goes to data-out or the data line by wire mode
  logic nxt_scl_lo;

  assign nxt_scl_lo = is_two_wire(wire_mode) &&
                      (start_flag_ff ||
                       ((wire_mode == universal_serial_shift_pkg::WIRE_TWO_HOLD) &&
                        ovf_flag_ff));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_ff <= 4'h0;
    end else begin
      req_ff[universal_serial_shift_pkg::REQ_DO_LVL] <= latch_ff;
      req_ff[universal_serial_shift_pkg::REQ_DO_EN]  <=
        (wire_mode == universal_serial_shift_pkg::WIRE_THREE);
      req_ff[universal_serial_shift_pkg::REQ_SDA_LO] <= is_two_wire(wire_mode) && !latch_ff;
      req_ff[universal_serial_shift_pkg::REQ_SCL_LO] <= nxt_scl_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and wake requests; deep-sleep wake only from two-wire mode
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq       <= 1'b0;
      wake_idle <= 1'b0;
      wake_deep <= 1'b0;
    end else begin
      irq       <= (ovf_flag_ff && overflow_irq_en) || (start_flag_ff && start_irq_en);
      wake_idle <= (ovf_flag_ff && overflow_irq_en) || (start_flag_ff && start_irq_en);
      wake_deep <= is_two_wire(wire_mode) &&
                   ((ovf_flag_ff && overflow_irq_en) || (start_flag_ff && start_irq_en));
    end
  end

  // status copies so every status output leaves from its own flip-flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_q                <= universal_serial_shift_pkg::DATA_RST;
      cnt_q                 <= universal_serial_shift_pkg::CNT_ZERO;
      counter_overflow_flag <= 1'b0;
      start_flag            <= 1'b0;
      rate_error            <= 1'b0;
    end else begin
      data_q                <= data_ff;
      cnt_q                 <= cnt_ff;
      counter_overflow_flag <= ovf_flag_ff;
      start_flag            <= start_flag_ff;
      rate_error            <= rate_err_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the system clock domain
  default clocking cb_sys @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_ovf_flag_set: assert property (ovf_evt |=> ovf_flag_ff ##1 counter_overflow_flag)
    else $error("overflow did not set the sticky flag");
  chk_cnt_wraps_zero: assert property (ovf_evt |=> cnt_ff == universal_serial_shift_pkg::CNT_ZERO)
    else $error("counter did not wrap to zero");
  chk_flag_is_sticky: assert property (ovf_flag_ff && !overflow_clr |=> ovf_flag_ff)
    else $error("overflow flag dropped without a clear");
  chk_shift_in_data: assert property (shift_evt && !data_wr_en |=>
      data_ff == {$past(data_ff[6:0]), $past(di_lvl)})
    else $error("shift did not take the data-input level");
  chk_ext_both_edges: assert property (src_ext && ext_edge && !cnt_wr_en |=>
      cnt_ff == $past(cnt_ff) + universal_serial_shift_pkg::CNT_STEP)
    else $error("external edge not counted");
  chk_ext_sample_edge: assert property (src_ext && ext_edge && !sample_edge && !data_wr_en |=>
      $stable(data_ff))
    else $error("register shifted on the output edge");
  chk_latch_closed: assert property (src_ext && (sck_lvl != clock_edge_select) |=>
      $stable(latch_ff))
    else $error("output latch changed in sampling phase");
  chk_scl_hold_start: assert property (start_evt |=> ##1 req_ff[universal_serial_shift_pkg::REQ_SCL_LO])
    else $error("clock not held low after start");
  chk_irq_overflow: assert property (ovf_evt && overflow_irq_en |=> ##1 irq ##1 counter_overflow_flag)
    else $error("overflow interrupt missing");
  chk_wake_deep_mode: assert property (wake_deep |-> $past(wire_mode[1]) && wake_idle)
    else $error("deep wake outside two-wire mode");
  chk_rate_two_wire: assert property (ext_edge && src_ext && is_two_wire(wire_mode) &&
      (gap_ff < universal_serial_shift_pkg::GAP_MIN_TWO) |=> ##1 rate_error)
    else $error("fast two-wire clock not flagged");

  cov_byte_done:     cover property (src_ext && ovf_evt);
  cov_start_seen:    cover property (start_evt ##[1:20] nxt_scl_lo);
  cov_soft_transfer: cover property (clock_source == universal_serial_shift_pkg::SRC_SOFT && ovf_evt);
  cov_rate_error:    cover property ($rose(rate_err_ff));

endmodule

`default_nettype wire

/* verif/serial_far_end.sv */
// far-side serial device: drives shift clock and data line, samples the
// core's data output. assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
`default_nettype none

module serial_far_end (
  input  wire logic link_clk,
  input  wire logic sdo_in,
  output logic      sck,
  output logic      sdo
);
  logic [7:0] got;

  //////////////////////////////////////////////////////////////////////
  // idle high on both lines so reset release sees no false edge
  initial begin
    sck = 1'b1;
    sdo = 1'b1;
    got = 8'h00;
  end

  // set both lines between frames; the clock stands still here
  task automatic lines(input logic c, input logic d);
    @(posedge link_clk);
    sck <= c;
    sdo <= d;
  endtask

  // one byte msb first; half is in link cycles and so sets the rate
  task automatic frame(input logic [7:0] tx, input logic ces, input int half);
    for (int i = 7; i >= 0; i--) begin
      @(posedge link_clk);
      sdo <= tx[i];
      repeat (half) @(posedge link_clk);
      got[i] = sdo_in;
      sck <= ~ces;
      repeat (half) @(posedge link_clk);
      sck <= ces;
    end
    repeat (half) @(posedge link_clk);
    sdo <= ~tx[0]; // released line must not keep a stale bit
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the serial shift core with a far-side model.
// assumes the core's pin requests reach the wires within a few cycles.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam logic [1:0] THREE = universal_serial_shift_pkg::WIRE_THREE;
  localparam logic [1:0] TWO   = universal_serial_shift_pkg::WIRE_TWO;
  localparam logic [1:0] HOLD  = universal_serial_shift_pkg::WIRE_TWO_HOLD;
  localparam logic [1:0] SOFT  = universal_serial_shift_pkg::SRC_SOFT;
  localparam logic [1:0] TIMER = universal_serial_shift_pkg::SRC_TIMER;
  localparam logic [1:0] EXT   = universal_serial_shift_pkg::SRC_EXT;
  logic       sys_clk, rst, link_clk, clock_edge_select, timer_match, soft_strobe;
  logic       data_wr_en, cnt_wr_en, overflow_clr, start_clr, rate_clr;
  logic       overflow_irq_en, start_irq_en, far_sck, far_sdo;
  logic [1:0] wire_mode, clock_source;
  logic [7:0] data_wr, data_q, d, r;
  logic [3:0] cnt_wr, cnt_q, c;
  logic       serial_in_pin_out, serial_in_pin_oe, shift_clock_pin_out, shift_clock_pin_oe;
  logic       data_out_pin, data_out_pin_oe, counter_overflow_flag, start_flag, rate_error;
  logic       irq, wake_idle, wake_deep, b;
  integer     seed, err_total, checks_done;
  wire logic  serial_in_pin, shift_clock_pin;
  wire logic [7:0] st;

  //////////////////////////////////////////////////////////////////////
  // wire levels: a pin the core pulls low overrides the far side
  assign shift_clock_pin = shift_clock_pin_oe ? shift_clock_pin_out : far_sck;
  assign serial_in_pin = serial_in_pin_oe ? serial_in_pin_out : far_sdo;
  assign st = {1'b0, wake_deep, wake_idle, shift_clock_pin_oe, irq, rate_error,
               start_flag, counter_overflow_flag};

  universal_serial_shift_core u_dut (.sys_clk, .rst, .link_clk, .wire_mode,
    .clock_source, .clock_edge_select, .timer_match, .soft_strobe, .data_wr_en,
    .data_wr, .cnt_wr_en, .cnt_wr, .overflow_clr, .start_clr, .rate_clr,
    .overflow_irq_en, .start_irq_en, .serial_in_pin, .serial_in_pin_out,
    .serial_in_pin_oe, .shift_clock_pin, .shift_clock_pin_out, .shift_clock_pin_oe,
    .data_out_pin, .data_out_pin_oe, .data_q, .cnt_q, .counter_overflow_flag,
    .start_flag, .rate_error, .irq, .wake_idle, .wake_deep);

  serial_far_end far (.link_clk(link_clk), .sdo_in(data_out_pin), .sck(far_sck),
    .sdo(far_sdo));

  // clocks: link clock offset so the two never line up
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #7.5 link_clk = ~link_clk;
  end

  // expected status from {deep, hold, irq, rate, start, ovf}; wake_idle follows irq
  function automatic logic [7:0] stat(input logic [5:0] v);
    return {1'b0, v[5], v[3], v[4], v[3], v[2], v[1], v[0]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // outputs show two edges after a request; sample mid-cycle when settled
  task automatic look;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // one-cycle pulse: 0 strobe, 1 timer, 2 overflow clear, 3 start clear, 4 rate clear
  task automatic pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: soft_strobe <= 1'b1;
      1: timer_match <= 1'b1;
      2: overflow_clr <= 1'b1;
      3: start_clr <= 1'b1;
      default: rate_clr <= 1'b1;
    endcase
    @(posedge sys_clk);
    {soft_strobe, timer_match, overflow_clr, start_clr, rate_clr} <= 5'h00;
  endtask

  task automatic load(input logic [7:0] dv, input logic [3:0] cv);
    @(posedge sys_clk);
    data_wr <= dv;
    data_wr_en <= 1'b1;
    cnt_wr <= cv;
    cnt_wr_en <= 1'b1;
    @(posedge sys_clk);
    {data_wr_en, cnt_wr_en} <= 2'h0;
    look;
  endtask

  // a hang ends the run through the same report
  initial begin
    #2000000;
    err_total++;
    wrap_up;
  end

  initial begin
    seed = 32'hb2ba;
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    {clock_edge_select, timer_match, soft_strobe, data_wr_en, cnt_wr_en} = 5'h00;
    {overflow_clr, start_clr, rate_clr, overflow_irq_en, start_irq_en} = 5'h03;
    {wire_mode, clock_source, data_wr, cnt_wr} = 16'h0000;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    look;
    chk(data_q, 8'h00);
    chk(8'(cnt_q), 8'h00);
    chk(st, stat(6'h00));
    // random loads, then strobes shift the data-in level in at the lsb
    for (int m = 0; m < 2; m++) begin
      wire_mode <= 2'(m);
      d = 8'($random(seed));
      c = 4'($random(seed));
      load(d, c);
      chk(data_q, d);
      chk(8'(cnt_q), 8'(c));
      for (int i = 0; i < 4; i++) begin
        b = 1'($random(seed));
        far.lines(1'b1, b);
        repeat (8) @(posedge sys_clk);
        pulse(0);
        d = {d[6:0], b};
        c = c + 4'h1;
        look;
        chk(data_q, d);
        chk(8'(cnt_q), 8'(c));
      end
    end
    // wrap from fifteen sets a sticky flag, gated onto the interrupt
    pulse(2);
    load(d, 4'hF);
    pulse(0);
    look;
    chk(8'(cnt_q), 8'h00);
    chk(st, stat(6'b001001));
    pulse(0);
    @(posedge sys_clk);
    overflow_irq_en <= 1'b0;
    look;
    chk(8'(cnt_q), 8'h01);
    chk(st, stat(6'b000001));
    overflow_irq_en <= 1'b1;
    pulse(2);
    look;
    chk(st, stat(6'h00));
    // timer source: soft strobe ignored, sixteenth match overflows
    clock_source <= TIMER;
    load(d, 4'h0);
    pulse(0);
    for (int i = 0; i < 15; i++)
      pulse(1);
    look;
    chk(8'(cnt_q), 8'h0F);
    chk(st, stat(6'h00));
    pulse(1);
    look;
    chk(st, stat(6'b001001));
    // three-wire byte exchange in both edge modes, second byte overwrites
    for (int e = 0; e < 2; e++) begin
      @(posedge sys_clk);
      clock_source <= SOFT;
      wire_mode <= THREE;
      clock_edge_select <= 1'(e);
      far.lines(1'(e), 1'b1);
      d = 8'($random(seed));
      load(d, 4'h0);
      clock_source <= EXT;
      for (int f = 0; f < 2; f++) begin
        pulse(2);
        r = 8'($random(seed));
        far.frame(r, 1'(e), 40);
        look;
        chk(far.got, d);
        chk(data_q, r);
        chk(8'(cnt_q), 8'h00);
        chk(st, stat(6'b001001));
        chk(8'(data_out_pin_oe), 8'h01);
        d = r;
      end
    end
    // rate limit: too fast for three-wire, fine there, too fast for two-wire
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      wire_mode <= (k == 2) ? TWO : THREE;
      clock_edge_select <= 1'b0;
      far.lines(1'b0, 1'b1);
      repeat (8) @(posedge sys_clk);
      pulse(4);
      far.frame(8'($random(seed)), 1'b0, (k == 0) ? 5 : 20);
      look;
      chk(8'(rate_error), (k == 1) ? 8'h00 : 8'h01);
    end
    // two-wire start: data falls while clock high, clock then held low
    @(posedge sys_clk);
    wire_mode <= TWO;
    clock_source <= SOFT;
    far.lines(1'b1, 1'b1);
    load(8'hFF, 4'h0);
    pulse(2);
    pulse(3);
    pulse(4);
    far.lines(1'b1, 1'b0);
    repeat (20) @(posedge sys_clk);
    look;
    chk(st, stat(6'b111010));
    pulse(3);
    look;
    chk(st, stat(6'h00));
    far.lines(1'b1, 1'b1);
    // hold mode: overflow also holds the clock low
    @(posedge sys_clk);
    wire_mode <= HOLD;
    load(8'hFF, 4'hF);
    pulse(0);
    look;
    chk(data_q, 8'hFF);
    chk(st, stat(6'b111001));
    chk(8'({serial_in_pin_oe, serial_in_pin_out, shift_clock_pin_out, data_out_pin_oe}), 8'h00);
    // msb low in two-wire mode pulls the data line instead of data-out
    load(8'h7F, 4'h0);
    chk(8'({serial_in_pin_oe, serial_in_pin_out, data_out_pin_oe}), 8'h04);
    wrap_up;
  end
endmodule
`default_nettype wire
